// ===== hw/adco_axis_drive.v
// Per-axis motor-off, reverse trippoint, drive type and general output logic
// What this block does
// - Motor-off disables named axes, or all when none named; others unchanged.
// - Per-axis off state reads 1 when off, 0 under servo.
// - Encoder position keeps tracking while the axis is off.
// - Status word two bit zero reads 0 when the axis is off.
// - Reverse trippoint stalls next command until axis crosses position moving negative.
// - Trippoint position is signed 32-bit quadrature counts.
// - Trippoint compares absolute position once per servo sample.
// - Trippoint also works on monitored or externally driven axes.
// - Drive codes: 1 servo, -1 servo reversed, 2 step low, -2 step high.
// - Reversed polarity inverts analog command or step pulse level.
// - Servo gets analog command; stepper gets step and direction outputs.
// - Switch word bit zero reads 1 with stepper jumper fitted; axis one at 105.
// - Output-bit command drives 1 for non-zero value, 0 for zero.
// - Output bits 1 to 8 on small, 1 to 16 on large controllers.
// - Output port mirrored in shared memory; host writes change outputs immediately.
// - No-operation command affects nothing; comment length 37 or 77.
`timescale 1ns/10ps
`include "adco_defs.vh"

module adco_axis_drive #(
  parameter SAMPLE_CYC = `ADCO_SAMPLE_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire wide_model,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [7:0] cmd_axis_mask,
  input wire signed [31:0] cmd_value,
  input wire [3:0] cmd_bit_index,
  input wire [6:0] cmd_nop_len,
  input wire [7:0] axis_moving,
  input wire [8*32-1:0] enc_pos,
  input wire [8*16-1:0] loop_cmd,
  input wire [7:0] step_pulse_raw,
  input wire [7:0] step_dir_raw,
  input wire [7:0] stepper_select_jumper,
  input wire mem_wr,
  input wire mem_rd,
  input wire [11:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata,
  output reg cmd_ready,
  output reg cmd_error,
  output reg [7:0] axis_off_state,
  output reg [8*3-1:0] drive_type_value,
  output reg [8*16-1:0] analog_cmd,
  output reg [7:0] step_out,
  output reg [7:0] dir_out,
  output reg [15:0] gen_out,
  output reg trip_busy,
  output reg [31:0] pos_latched
);

  // Command codes
  localparam [2:0] OP_NOP = 3'h0;
  localparam [2:0] OP_OFF = 3'h1;
  localparam [2:0] OP_ON = 3'h2;
  localparam [2:0] OP_TRIP = 3'h3;
  localparam [2:0] OP_TYPE = 3'h4;
  localparam [2:0] OP_OBIT = 3'h5;

  reg [21:0] sample_cnt_reg;
  reg sample_tick_reg;
  reg [2:0] trip_axis_reg;
  reg signed [31:0] trip_pos_reg;
  reg signed [31:0] prev_pos_reg;
  wire [7:0] all_mask;
  wire [7:0] axes_mask;
  wire [15:0] obit_mask;
  reg [2:0] trip_sel;
  wire trip_one_hot;
  wire signed [31:0] trip_cur;
  wire [7:0] sel_moving;
  wire cmd_bad;
  wire bad_moving;
  wire bad_trip_mask;
  wire type_code_ok;
  wire bad_type_code;
  wire bad_bit_index;
  wire bad_nop_len;
  wire moved_back;
  wire at_or_past;
  wire hit_switch;
  wire hit_status;
  wire [2:0] axis_slot;
  integer k;

  assign all_mask = wide_model ? 8'hff : 8'h0f;
  // No axes named means every present axis
  assign axes_mask = (cmd_axis_mask == 8'h00) ? all_mask : (cmd_axis_mask & all_mask);
  assign obit_mask = 16'h0001 << cmd_bit_index;
  assign sel_moving = axes_mask & axis_moving;
  assign trip_one_hot = (cmd_axis_mask != 8'h00) &&
                        ((cmd_axis_mask & (cmd_axis_mask - 8'h01)) == 8'h00) &&
                        ((cmd_axis_mask & ~all_mask) == 8'h00);

  // Axis number of the single named trippoint axis
  always @* begin
    trip_sel = 3'h0;
    if (cmd_axis_mask[7]) begin
      trip_sel = 3'h7;
    end else if (cmd_axis_mask[6]) begin
      trip_sel = 3'h6;
    end else if (cmd_axis_mask[5]) begin
      trip_sel = 3'h5;
    end else if (cmd_axis_mask[4]) begin
      trip_sel = 3'h4;
    end else if (cmd_axis_mask[3]) begin
      trip_sel = 3'h3;
    end else if (cmd_axis_mask[2]) begin
      trip_sel = 3'h2;
    end else if (cmd_axis_mask[1]) begin
      trip_sel = 3'h1;
    end
  end

  // Encoder position always live, motor off or not
  assign trip_cur = enc_pos[trip_axis_reg*32 +: 32];
  // Position fell since the last sample
  assign moved_back = trip_cur < prev_pos_reg;
  // At or beyond the target on the negative side
  assign at_or_past = trip_cur <= trip_pos_reg;
  // Motor-off and drive type refused on a moving axis
  assign bad_moving = (cmd_op == OP_OFF || cmd_op == OP_TYPE) &&
                      (sel_moving != 8'h00);
  // Trippoint needs exactly one present axis
  assign bad_trip_mask = (cmd_op == OP_TRIP) && !trip_one_hot;
  // Only the four drive codes are legal
  assign type_code_ok = (cmd_value == 32'sd1) || (cmd_value == -32'sd1) ||
                        (cmd_value == 32'sd2) || (cmd_value == -32'sd2);
  assign bad_type_code = (cmd_op == OP_TYPE) && !type_code_ok;
  // Output bit beyond the port of this model
  assign bad_bit_index = (cmd_op == OP_OBIT) &&
                         (cmd_bit_index > (wide_model ? 4'hf : 4'h7));
  // Comment text longer than the model allows
  assign bad_nop_len = (cmd_op == OP_NOP) &&
    (cmd_nop_len > (wide_model ? 7'd`ADCO_NOP_MAX_WIDE : 7'd`ADCO_NOP_MAX_SMALL));
  // Any failed argument check rejects the command
  assign cmd_bad = bad_moving || bad_trip_mask || bad_type_code || bad_bit_index || bad_nop_len;
  // Per-axis word windows in shared memory
  assign hit_switch = (mem_addr >= `ADCO_OFS_SWITCH_BASE) &&
                      (mem_addr < `ADCO_OFS_SWITCH_BASE + 12'h008);
  assign hit_status = (mem_addr >= `ADCO_OFS_STATUS2_BASE) &&
                      (mem_addr < `ADCO_OFS_STATUS2_BASE + 12'h008);
  // Axis number from the low address bits
  assign axis_slot = mem_addr[2:0] - 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Servo sample timebase
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt_reg <= 22'h0;
      sample_tick_reg <= 1'b0;
    end else if (sample_cnt_reg == SAMPLE_CYC - 1) begin
      sample_cnt_reg <= 22'h0;
      sample_tick_reg <= 1'b1;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 22'h1;
      sample_tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command execution, trippoint stall and output port
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b1;
      cmd_error <= 1'b0;
      axis_off_state <= 8'h00;
      drive_type_value <= {8{`ADCO_MT_RESET}};
      gen_out <= 16'h0000;
      trip_busy <= 1'b0;
      trip_axis_reg <= 3'h0;
      trip_pos_reg <= 32'sd0;
      prev_pos_reg <= 32'sd0;
      pos_latched <= 32'h0;
    end else begin
      cmd_error <= 1'b0;
      if (trip_busy) begin
        // Checked only on sample ticks, so crossing may be late by one sample
        if (sample_tick_reg) begin
          prev_pos_reg <= trip_cur;
          // Crossing the point while travelling negative
          if (moved_back && at_or_past) begin
            trip_busy <= 1'b0;
            cmd_ready <= 1'b1;
            pos_latched <= trip_cur;
          end
        end
      end else if (cmd_valid) begin
        if (cmd_bad) begin
          cmd_error <= 1'b1;
        end else begin
          case (cmd_op)
            OP_OFF: axis_off_state <= axis_off_state | axes_mask;
            OP_ON: axis_off_state <= axis_off_state & ~axes_mask;
            OP_TRIP: begin
              // Stall further commands until crossing
              trip_busy <= 1'b1;
              cmd_ready <= 1'b0;
              trip_axis_reg <= trip_sel;
              trip_pos_reg <= cmd_value;
              prev_pos_reg <= enc_pos[trip_sel*32 +: 32];
            end
            OP_TYPE: begin
              for (k = 0; k < 8; k = k + 1) begin
                if (axes_mask[k]) begin
                  drive_type_value[k*3 +: 3] <= cmd_value[2:0];
                end
              end
            end
            OP_OBIT: begin
              // Non-zero expression value drives a one
              if (cmd_value != 32'sd0) begin
                gen_out <= gen_out | obit_mask;
              end else begin
                gen_out <= gen_out & ~obit_mask;
              end
            end
            default: ; // No-operation leaves everything alone
          endcase
        end
      end
      // Host write to the mirror changes outputs at once
      if (mem_wr) begin
        if (!wide_model && mem_addr == `ADCO_OFS_OUT_BYTE) begin
          gen_out[7:0] <= mem_wdata;
        end else if (wide_model && mem_addr == `ADCO_OFS_OUT_WIDE_LO) begin
          gen_out[7:0] <= mem_wdata;
        end else if (wide_model && mem_addr == `ADCO_OFS_OUT_WIDE_HI) begin
          gen_out[15:8] <= mem_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared memory read port
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      if (!wide_model && mem_addr == `ADCO_OFS_OUT_BYTE) begin
        mem_rdata <= gen_out[7:0];
      end else if (wide_model && mem_addr == `ADCO_OFS_OUT_WIDE_LO) begin
        mem_rdata <= gen_out[7:0];
      end else if (wide_model && mem_addr == `ADCO_OFS_OUT_WIDE_HI) begin
        mem_rdata <= gen_out[15:8];
      end else if (hit_switch) begin
        // Stepper jumper presence
        mem_rdata <= {7'h00, stepper_select_jumper[axis_slot]};
      end else if (hit_status) begin
        // Bit zero low when motor off
        mem_rdata <= {7'h00, ~axis_off_state[axis_slot]};
      end else begin
        mem_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-axis drive outputs
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_axis
      wire [2:0] mt = drive_type_value[g*3 +: 3];
      wire is_step = (mt == `ADCO_MT_STEP_LOW) || (mt == `ADCO_MT_STEP_HIGH);
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          analog_cmd[g*16 +: 16] <= 16'h0000;
          step_out[g] <= 1'b1;
          dir_out[g] <= 1'b0;
        end else if (axis_off_state[g]) begin
          // Loop disabled: zero command, step idle
          analog_cmd[g*16 +: 16] <= 16'h0000;
          step_out[g] <= (mt == `ADCO_MT_STEP_LOW);
          dir_out[g] <= 1'b0;
        end else if (is_step) begin
          // Step pulses only when jumper fitted; direction passed through regardless
          analog_cmd[g*16 +: 16] <= 16'h0000;
          step_out[g] <= (step_pulse_raw[g] & stepper_select_jumper[g]) ^
                         (mt == `ADCO_MT_STEP_LOW);
          dir_out[g] <= step_dir_raw[g];
        end else begin
          // Full-scale code spans plus or minus ten volts
          analog_cmd[g*16 +: 16] <= (mt == `ADCO_MT_SERVO_REV) ?
            16'h0000 - loop_cmd[g*16 +: 16] : loop_cmd[g*16 +: 16];
          step_out[g] <= 1'b1;
          dir_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ===== hw/adco_defs.vh
// Constants for the axis drive configuration and output block
`ifndef ADCO_DEFS_VH
`define ADCO_DEFS_VH
`define ADCO_NUM_AXES 8
`define ADCO_SMALL_OUT_BITS 8
`define ADCO_WIDE_OUT_BITS 16
`define ADCO_OFS_OUT_BYTE 12'h02b
`define ADCO_OFS_OUT_WIDE_LO 12'h02e
`define ADCO_OFS_OUT_WIDE_HI 12'h02f
`define ADCO_OFS_SWITCH_BASE 12'h105
`define ADCO_OFS_STATUS2_BASE 12'h115
`define ADCO_SWITCH_STEP_BIT 0
`define ADCO_STATUS2_ON_BIT 0
`define ADCO_MT_SERVO 3'sd1
`define ADCO_MT_SERVO_REV -3'sd1
`define ADCO_MT_STEP_LOW 3'sd2
`define ADCO_MT_STEP_HIGH -3'sd2
`define ADCO_MT_RESET 3'h1
`define ADCO_SAMPLE_NS 2000000
`define ADCO_CLK_NS 10
`define ADCO_SAMPLE_CYC (`ADCO_SAMPLE_NS / `ADCO_CLK_NS)
`define ADCO_NOP_MAX_SMALL 37
`define ADCO_NOP_MAX_WIDE 77
`endif

// ===== bench/adco_axis_drive_asserts.sv
// Port checker for the axis drive block
`timescale 1ns/10ps
module adco_axis_drive_asserts (
  input wire clk_sys,
  input wire rst_n,
  input wire wide_model,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [7:0] cmd_axis_mask,
  input wire signed [31:0] cmd_value,
  input wire [3:0] cmd_bit_index,
  input wire [7:0] axis_moving,
  input wire mem_wr,
  input wire mem_rd,
  input wire [11:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire cmd_ready,
  input wire cmd_error,
  input wire [7:0] axis_off_state,
  input wire [8*16-1:0] analog_cmd,
  input wire [15:0] gen_out,
  input wire trip_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Command taken at this edge
  wire tk = cmd_valid && !trip_busy;
  wire idle = axis_moving == 8'h00;
  all_off_a: assert property (tk && cmd_op == 3'h1 && cmd_axis_mask == 8'h00 && wide_model
    && idle |=> axis_off_state == 8'hff) else $error("all off wrong");
  servo_on_a: assert property (tk && cmd_op == 3'h2 && cmd_axis_mask == 8'h00 && wide_model
    |=> axis_off_state == 8'h00) else $error("servo on wrong");
  trip_stall_a: assert property (trip_busy |-> !cmd_ready)
    else $error("ready during trip");
  off_analog_a: assert property (axis_off_state[0] && $past(axis_off_state[0])
    |-> analog_cmd[15:0] == 16'h0000) else $error("analog on off axis");
  bad_type_a: assert property (tk && cmd_op == 3'h4 && cmd_value == 32'sd3
    |-> ##[1:2] cmd_error) else $error("bad type kept");
  out_bit_a: assert property (tk && cmd_op == 3'h5 && wide_model && cmd_value != 0 && !mem_wr
    |=> gen_out[$past(cmd_bit_index)]) else $error("output bit low");
  status_rd_a: assert property (mem_rd && mem_addr == 12'h115
    |=> mem_rdata[0] == !$past(axis_off_state[0])) else $error("status bit wrong");
  host_wr_a: assert property (mem_wr && mem_addr == 12'h02e && wide_model
    |=> gen_out[7:0] == $past(mem_wdata)) else $error("host write lost");
  cover property (tk && cmd_op == 3'h3);
  cover property (cmd_error);
  cover property ($fell(trip_busy));
endmodule
bind adco_axis_drive adco_axis_drive_asserts chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .wide_model(wide_model), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_axis_mask(cmd_axis_mask),
  .cmd_value(cmd_value), .cmd_bit_index(cmd_bit_index), .axis_moving(axis_moving),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .cmd_error(cmd_error),
  .axis_off_state(axis_off_state), .analog_cmd(analog_cmd), .gen_out(gen_out),
  .trip_busy(trip_busy));

// ===== bench/adco_far_side.sv
// Far-side model: encoders, loop output, step generator and jumpers
`timescale 1ns/10ps
module adco_far_side (
  input wire clk_sys,
  input wire rst_n,
  input wire run,
  output reg [8*32-1:0] enc_pos,
  output wire [7:0] axis_moving,
  output wire [8*16-1:0] loop_cmd,
  output reg [7:0] step_pulse_raw,
  output wire [7:0] step_dir_raw,
  output wire [7:0] stepper_select_jumper
);
  // Axis 0 pushed backward by an outside drive while run is high
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enc_pos <= 256'h0;
      step_pulse_raw <= 8'h00;
    end else begin
      if (run) enc_pos[31:0] <= enc_pos[31:0] - 32'h7;
      step_pulse_raw <= ~step_pulse_raw;
    end
  end
  // Fixed levels except axis 0 moving with run; jumper only on axis 2
  assign axis_moving = {7'h00, run};
  assign loop_cmd = {8{16'h1234}};
  assign step_dir_raw = 8'h0f;
  assign stepper_select_jumper = 8'h04;
endmodule

// ===== bench/tb.sv
// Self-checking bench for the axis drive block
`timescale 1ns/10ps
module tb;
  reg clk_sys = 1'b0, rst_n = 1'b0, wide_model = 1'b1, cmd_valid = 1'b0, run = 1'b0;
  reg mem_wr = 1'b0, mem_rd = 1'b0, err = 1'b0;
  reg [2:0] cmd_op = 3'h0;
  reg [7:0] cmd_axis_mask = 8'h00, mem_wdata = 8'h00;
  reg signed [31:0] cmd_value = 32'h0;
  reg [3:0] cmd_bit_index = 4'h0;
  reg [6:0] cmd_nop_len = 7'h00;
  reg [11:0] mem_addr = 12'h000;
  wire [8*32-1:0] enc;
  wire [8*16-1:0] lc, analog_cmd;
  wire [7:0] mv, spr, sdr, jmp, mem_rdata, axis_off_state;
  wire [23:0] drive_type_value;
  wire [15:0] gen_out;
  wire [31:0] pos_latched;
  wire [7:0] step_out, dir_out;
  wire cmd_ready, cmd_error, trip_busy;
  integer mismatches = 0, n_checks = 0, cyc = 0, i, v;
  adco_far_side fs (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .enc_pos(enc),
    .axis_moving(mv), .loop_cmd(lc), .step_pulse_raw(spr), .step_dir_raw(sdr),
    .stepper_select_jumper(jmp));
  adco_axis_drive #(.SAMPLE_CYC(10)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .wide_model(wide_model), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_axis_mask(cmd_axis_mask), .cmd_value(cmd_value), .cmd_bit_index(cmd_bit_index),
    .cmd_nop_len(cmd_nop_len), .axis_moving(mv), .enc_pos(enc), .loop_cmd(lc),
    .step_pulse_raw(spr), .step_dir_raw(sdr), .stepper_select_jumper(jmp),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .cmd_error(cmd_error),
    .axis_off_state(axis_off_state), .drive_type_value(drive_type_value),
    .analog_cmd(analog_cmd), .step_out(step_out), .dir_out(dir_out), .gen_out(gen_out),
    .trip_busy(trip_busy), .pos_latched(pos_latched));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
    end
  endtask
  // One command, then error seen within three cycles
  task cmd(input [2:0] op, input [7:0] m, input [31:0] val, input [3:0] b);
    begin
      @(posedge clk_sys) #1;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_axis_mask = m;
      cmd_value = val;
      cmd_bit_index = b;
      @(posedge clk_sys) #1;
      cmd_valid = 1'b0;
      err = cmd_error;
      repeat (2) @(posedge clk_sys) #1 err = err | cmd_error;
    end
  endtask
  // Memory read, masked compare; memory write
  task mrd(input [11:0] a, input [7:0] k, input [7:0] e);
    begin
      @(posedge clk_sys) #1;
      mem_rd = 1'b1;
      mem_addr = a;
      @(posedge clk_sys) #1;
      mem_rd = 1'b0;
      chk(mem_rdata & k, e);
    end
  endtask
  task mwr(input [11:0] a, input [7:0] d);
    begin
      @(posedge clk_sys) #1;
      mem_wr = 1'b1;
      mem_addr = a;
      mem_wdata = d;
      @(posedge clk_sys) #1;
      mem_wr = 1'b0;
      @(posedge clk_sys) #1;
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  // Test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk({drive_type_value, axis_off_state}, 32'h24924900);
    chk(gen_out, 16'h0000);
    mrd(12'h105, 8'h01, 8'h00);
    mrd(12'h107, 8'h01, 8'h01);
    $display("reset and switch test done");
    cmd(3'h1, 8'h00, 0, 4'h0);
    chk(axis_off_state, 8'hff);
    chk(analog_cmd[15:0], 16'h0000);
    mrd(12'h115, 8'h01, 8'h00);
    cmd(3'h2, 8'h00, 0, 4'h0);
    chk(axis_off_state, 8'h00);
    mrd(12'h115, 8'h01, 8'h01);
    cmd(3'h1, 8'h05, 0, 4'h0);
    cmd(3'h1, 8'h10, 0, 4'h0);
    chk(axis_off_state, 8'h15);
    cmd(3'h2, 8'h00, 0, 4'h0);
    $display("motor off test done");
    for (i = 0; i < 4; i = i + 1) begin
      v = (i < 2 ? 1 : 2) * (i % 2 ? -1 : 1);
      cmd(3'h4, 8'h02, v, 4'h0);
      chk(drive_type_value[5:3], v[2:0]);
      if (i < 2) chk(analog_cmd[31:16], v[1] ? 16'hedcc : 16'h1234);
    end
    cmd(3'h4, 8'h02, 3, 4'h0);
    chk({err, drive_type_value[5:3]}, 4'he);
    chk(step_out[1], 0);
    cmd(3'h4, 8'h04, 2, 4'h0);
    chk({dir_out[2], step_out[2]}, {1'b1, spr[2]});
    chk(analog_cmd[47:32], 16'h0000);
    cmd(3'h4, 8'h04, -2, 4'h0);
    chk(step_out[2], !spr[2]);
    $display("drive type test done");
    cmd(3'h5, 8'h00, 5, 4'hf);
    chk(gen_out, 16'h8000);
    mrd(12'h02f, 8'hff, 8'h80);
    cmd(3'h5, 8'h00, 0, 4'hf);
    chk(gen_out, 16'h0000);
    mwr(12'h02e, 8'ha5);
    chk(gen_out, 16'h00a5);
    wide_model = 1'b0;
    cmd(3'h5, 8'h00, 1, 4'h8);
    chk({err, gen_out[7:0]}, 9'h1a5);
    cmd(3'h5, 8'h00, 1, 4'h6);
    chk(gen_out[7:0], 8'he5);
    mwr(12'h02b, 8'h3c);
    chk(gen_out[7:0], 8'h3c);
    cmd_nop_len = 7'd38;
    cmd(3'h0, 8'h00, 0, 4'h0);
    chk(err, 1);
    cmd_nop_len = 7'd37;
    cmd(3'h0, 8'h00, 0, 4'h0);
    chk({err, gen_out[7:0]}, 9'h03c);
    wide_model = 1'b1;
    $display("output test done");
    cmd(3'h1, 8'h01, 0, 4'h0);
    run = 1'b1;
    cmd(3'h4, 8'h01, -1, 4'h0);
    chk({err, drive_type_value[2:0]}, 4'h9);
    cmd(3'h3, 8'h03, -300, 4'h0);
    chk({err, trip_busy}, 2'b10);
    cmd(3'h3, 8'h01, -300, 4'h0);
    chk({trip_busy, cmd_ready}, 2'b10);
    for (i = 0; trip_busy && i < 200; i = i + 1) @(posedge clk_sys) #1;
    chk({trip_busy, cmd_ready}, 2'b01);
    chk($signed(pos_latched) <= -300 && $signed(pos_latched) > -380, 1);
    run = 1'b0;
    $display("trip test done");
    wrap_up;
  end
endmodule
